/* logic/rdb_dma_seq.sv */
/*
 slave dma sequencer: counts bytes and bursts against the acknowledge pin.
 assumes dma_ack_i is an asynchronous pin, active high, one pulse per beat.
*/
module rdb_dma_seq #(
   parameter int COUNT_W = 24
)(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // control
   input wire logic run_i,
   input wire logic [COUNT_W-1:0] count_i,
   input wire logic [1:0] burst_length_sel_i,
   input wire logic bus_wide_i,
   // pin side
   input wire logic dma_ack_i,
   output logic dma_req_o,
   // status
   output logic done_o,
   output logic [COUNT_W-1:0] remaining_o,
   output logic [15:0] bursts_o
);
   typedef enum logic [1:0] {S_IDLE, S_RUN, S_HOLD} rdb_seq_t;

   // the count field is at most 24 bits and the byte step needs 3 low bits
   if (COUNT_W < 4 || COUNT_W > 24)
   begin : g_bad_count
      $error("rdb_dma_seq: COUNT_W out of range");
   end

   rdb_seq_t state_reg, state_next;
   logic [2:0] ack_sync_reg;
   logic ack_level_reg, ack_level_next;
   logic [COUNT_W-1:0] rem_reg, rem_next;
   logic [4:0] beat_reg, beat_next;
   logic [15:0] burst_reg, burst_next;
   logic req_reg, req_next;
   logic done_reg, done_next;
   logic beat_seen;
   logic [COUNT_W-1:0] step;

   // third stage filters glitches: a change counts once two stages agree
   always_comb
   begin
      ack_level_next = ack_level_reg;
      if (ack_sync_reg[1] == ack_sync_reg[2])
         ack_level_next = ack_sync_reg[2];
   end

   assign beat_seen = ack_level_next & ~ack_level_reg;
   assign step = {{(COUNT_W-3){1'b0}}, rdb_pkg::beat_bytes(bus_wide_i)}; // R5

   always_comb
   begin
      state_next = state_reg;
      rem_next = rem_reg;
      beat_next = beat_reg;
      burst_next = burst_reg;
      req_next = req_reg;
      done_next = 1'b0;
      case (state_reg)
         S_IDLE:
         begin
            if (run_i && count_i != '0) // R7
            begin
               state_next = S_RUN;
               rem_next = count_i; // R4
               beat_next = '0;
               burst_next = '0;
               req_next = 1'b1;
            end
         end
         S_RUN:
         begin
            if (!run_i) // R7
            begin
               state_next = S_HOLD;
               req_next = 1'b0;
            end
            else if (beat_seen)
            begin
               rem_next = (rem_reg > step) ? rem_reg - step : '0; // R5
               beat_next = beat_reg + 5'h01;
               if (rem_next == '0 || beat_next ==
                   rdb_pkg::burst_beats(burst_length_sel_i)) // R6
               begin
                  burst_next = burst_reg + 16'h0001;
                  beat_next = '0;
               end
               if (rem_next == '0)
               begin
                  state_next = S_HOLD;
                  req_next = 1'b0;
                  done_next = 1'b1;
               end
            end
         end
         S_HOLD:
         begin
            // wait for run to drop before another start; hardware clears it on done
            if (!run_i)
               state_next = S_IDLE;
         end
         default:
            state_next = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= S_IDLE;
         ack_sync_reg <= 3'h0;
         ack_level_reg <= 1'b0;
         rem_reg <= '0;
         beat_reg <= 5'h00;
         burst_reg <= 16'h0000;
         req_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         ack_sync_reg <= {ack_sync_reg[1:0], dma_ack_i};
         ack_level_reg <= ack_level_next;
         rem_reg <= rem_next;
         beat_reg <= beat_next;
         burst_reg <= burst_next;
         req_reg <= req_next;
         done_reg <= done_next;
      end
   end

   assign dma_req_o = req_reg;
   assign done_o = done_reg;
   assign remaining_o = rem_reg;
   assign bursts_o = burst_reg;

   property p_stop_drops_req;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_reg == S_RUN && !run_i) |=> !dma_req_o;
   endproperty
   a_stop_drops_req: assert property (p_stop_drops_req) // R7
      else $error("request stays after run cleared");

   property p_start_loads;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_reg == S_IDLE && run_i && count_i != '0)
      |=> (remaining_o == $past(count_i) && dma_req_o);
   endproperty
   a_start_loads: assert property (p_start_loads) // R4
      else $error("start did not load byte count");

   property p_step_bytes;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_reg == S_RUN && run_i && beat_seen && rem_reg > step)
      |=> remaining_o == $past(rem_reg) - $past(step);
   endproperty
   a_step_bytes: assert property (p_step_bytes) // R5
      else $error("byte count step wrong for bus width");

   property p_burst_length_sel;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (state_reg == S_RUN && run_i && beat_seen && rem_next != '0
       && beat_reg + 5'h01 == rdb_pkg::burst_beats(burst_length_sel_i))
      |=> (bursts_o == $past(burst_reg) + 16'h0001 && beat_reg == '0);
   endproperty
   a_burst_length_sel: assert property (p_burst_length_sel) // R6
      else $error("burst not closed at selected length");

   c_done: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      done_o);
   c_abort: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      state_reg == S_RUN && !run_i);
endmodule // rdb_dma_seq

/* logic/rdb_pkg.sv */
/*
 package for the reset, dma configuration and area-filled register bank.
 assumes a 32-bit processor interface with word offsets as byte addresses.
*/
package rdb_pkg;
   // register byte offsets
   localparam logic [11:0] SOFTWARE_RESET_CONTROL_OFS = 12'h030c;
   localparam logic [11:0] DMA_CFG_OFS = 12'h0330;
   localparam logic [11:0] AREA_FILLED_OFS = 12'h0334;
   // software reset fields
   localparam int RST_ALL_BIT = 0;
   localparam int RST_CORE_BIT = 1;
   // dma configuration fields
   localparam int DMA_DIR_BIT = 0;
   localparam int DMA_RUN_BIT = 1;
   localparam int BURST_LO = 2;
   localparam int BURST_HI = 3;
   localparam int COUNT_LO = 8;
   localparam int COUNT_HI = 31;
   localparam int COUNT_W = 24;
   // area filled fields
   localparam int ASYNC_BIT = 0;
   localparam int INTR_BIT = 1;
   localparam int ISO_BIT = 2;
   localparam int AREA_W = 3;
   // reset values
   localparam logic [31:0] DMA_CFG_RST = 32'h0000_0000;
   localparam logic [2:0] AREA_RST = 3'h0;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;
   // bus widths in bytes per beat
   localparam logic [2:0] BYTES_16 = 3'h2;
   localparam logic [2:0] BYTES_32 = 3'h4;

   typedef enum logic [1:0] {
      BURST_SINGLE,
      BURST_4,
      BURST_8,
      BURST_16
   } rdb_burst_t;

   // beats per burst for a burst length selection
   function automatic logic [4:0] burst_beats(input logic [1:0] sel);
      case (rdb_burst_t'(sel))
         BURST_SINGLE: burst_beats = 5'h01;
         BURST_4: burst_beats = 5'h04;
         BURST_8: burst_beats = 5'h08;
         default: burst_beats = 5'h10;
      endcase
   endfunction

   function automatic logic [2:0] beat_bytes(input logic wide);
      beat_bytes = wide ? BYTES_32 : BYTES_16;
   endfunction
endpackage

/* logic/rdb_regs.sv */
/*
 software reset, dma configuration and area-filled registers with the
 slave dma sequencer. assumes a synchronous processor port on clk_sys_i
 where strobes are one-cycle pulses qualified by chip select.
*/
// Notes on behaviour
// R1: core reset bit pulses a reset for host core registers below 300h only.
// R2: full reset bit resets every register, including this bank.
// R3: reserved bits have no function; software writes them as zero.
// R4: dma configuration holds a 24-bit byte count in bits 31 to 8.
// R5: burst count depends on 16 or 32 bit data bus width.
// R6: burst select 00 single, 01 four, 10 eight, 11 sixteen beats.
// R7: run bit starts the transfer; clearing it terminates it.
// R8: direction bit 0 writes internal ram, 1 reads internal ram.
// R9: software sets a filled flag when an area holds descriptors.
// R10: a set flag lets the core walk valid, unskipped descriptor headers.
// R11: filled flags may be written during initialisation and are accepted.
// R12: flags iso bit 2, interrupt bit 1, async bit 0; zero skips area.
module rdb_regs #(
   parameter int COUNT_W = 24
)(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // processor register port
   input wire logic cpu_cs_i,
   input wire logic cpu_wr_i,
   input wire logic cpu_rd_i,
   input wire logic [11:0] cpu_addr_i,
   input wire logic [31:0] cpu_wdata_i,
   output logic [31:0] cpu_rdata_o,
   output logic cpu_rvalid_o,
   // configuration from the processor interface block
   input wire logic bus_wide_i,
   // reset requests
   output logic core_regs_reset_o,
   output logic all_regs_reset_o,
   // dma pins
   input wire logic dma_ack_i,
   output logic dma_req_o,
   output logic dma_to_ram_o,
   output logic dma_done_o,
   // scheduler side
   output logic async_area_filled_o,
   output logic intr_area_filled_o,
   output logic iso_area_filled_o
);
   if (COUNT_W != rdb_pkg::COUNT_W)
   begin : g_bad_count
      $error("rdb_regs: COUNT_W must match the count field");
   end

   logic wr_en, rd_en;
   logic [31:0] dma_cfg_reg, dma_cfg_next;
   logic [2:0] area_reg, area_next;
   logic core_rst_reg, core_rst_next;
   logic all_rst_reg, all_rst_next;
   logic [31:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   logic to_ram_reg, to_ram_next;
   logic seq_done;

   assign wr_en = cpu_cs_i & cpu_wr_i;
   assign rd_en = cpu_cs_i & cpu_rd_i;

   always_comb
   begin
      dma_cfg_next = dma_cfg_reg;
      area_next = area_reg;
      core_rst_next = 1'b0;
      all_rst_next = 1'b0;
      // hardware clears run when the count is exhausted
      if (seq_done)
         dma_cfg_next[rdb_pkg::DMA_RUN_BIT] = 1'b0;
      if (all_rst_reg) // R2
      begin
         dma_cfg_next = rdb_pkg::DMA_CFG_RST;
         area_next = rdb_pkg::AREA_RST;
      end
      else if (wr_en)
      begin
         case (cpu_addr_i)
            rdb_pkg::SOFTWARE_RESET_CONTROL_OFS:
            begin
               // reset bits are pulses and read back as zero
               core_rst_next = cpu_wdata_i[rdb_pkg::RST_CORE_BIT]; // R1
               all_rst_next = cpu_wdata_i[rdb_pkg::RST_ALL_BIT]; // R2
            end
            rdb_pkg::DMA_CFG_OFS:
            begin
               // only defined fields are stored; reserved bits stay zero
               dma_cfg_next = {cpu_wdata_i[rdb_pkg::COUNT_HI:
                                           rdb_pkg::COUNT_LO],
                               4'h0,
                               cpu_wdata_i[rdb_pkg::BURST_HI:
                                           rdb_pkg::DMA_DIR_BIT]}; // R3 R4
            end
            rdb_pkg::AREA_FILLED_OFS:
               // accepted at any time except while the full reset pulse is high, including before any dma use
               area_next = cpu_wdata_i[rdb_pkg::AREA_W-1:0]; // R9 R11 R12
            default:
            begin
            end
         endcase
      end
   end

   // direction is latched at start so a mid-transfer change cannot flip it
   always_comb
   begin
      to_ram_next = to_ram_reg;
      if (!dma_req_o)
         to_ram_next = ~dma_cfg_reg[rdb_pkg::DMA_DIR_BIT]; // R8
      if (all_rst_reg)
         to_ram_next = 1'b1;
   end

   always_comb
   begin
      rdata_next = rdata_reg;
      rvalid_next = rd_en;
      if (rd_en)
      begin
         case (cpu_addr_i)
            rdb_pkg::SOFTWARE_RESET_CONTROL_OFS:
               rdata_next = rdb_pkg::RDATA_RST;
            rdb_pkg::DMA_CFG_OFS:
               rdata_next = dma_cfg_reg;
            rdb_pkg::AREA_FILLED_OFS:
               rdata_next = {{(32-rdb_pkg::AREA_W){1'b0}}, area_reg}; // R3
            default:
               rdata_next = rdb_pkg::RDATA_RST;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         dma_cfg_reg <= rdb_pkg::DMA_CFG_RST;
         area_reg <= rdb_pkg::AREA_RST;
         core_rst_reg <= 1'b0;
         all_rst_reg <= 1'b0;
         rdata_reg <= rdb_pkg::RDATA_RST;
         rvalid_reg <= 1'b0;
         to_ram_reg <= 1'b1;
      end
      else
      begin
         dma_cfg_reg <= dma_cfg_next;
         area_reg <= area_next;
         core_rst_reg <= core_rst_next;
         all_rst_reg <= all_rst_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
         to_ram_reg <= to_ram_next;
      end
   end

   rdb_dma_seq #(
      .COUNT_W(COUNT_W)
   ) u_seq (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .run_i(dma_cfg_reg[rdb_pkg::DMA_RUN_BIT]), // R7
      .count_i(dma_cfg_reg[rdb_pkg::COUNT_HI:rdb_pkg::COUNT_LO]), // R4
      .burst_length_sel_i(dma_cfg_reg[rdb_pkg::BURST_HI:
                                      rdb_pkg::BURST_LO]), // R6
      .bus_wide_i(bus_wide_i), // R5
      .dma_ack_i(dma_ack_i),
      .dma_req_o(dma_req_o),
      .done_o(seq_done),
      .remaining_o(),
      .bursts_o()
   );

   assign cpu_rdata_o = rdata_reg;
   assign cpu_rvalid_o = rvalid_reg;
   // core reset covers only core registers, never this bank
   assign core_regs_reset_o = core_rst_reg; // R1
   assign all_regs_reset_o = all_rst_reg; // R2
   assign dma_to_ram_o = to_ram_reg; // R8
   assign dma_done_o = seq_done;
   assign async_area_filled_o = area_reg[rdb_pkg::ASYNC_BIT]; // R10 R12
   assign intr_area_filled_o = area_reg[rdb_pkg::INTR_BIT]; // R10 R12
   assign iso_area_filled_o = area_reg[rdb_pkg::ISO_BIT]; // R10 R12

   property p_core_rst_pulse;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (wr_en && !all_rst_reg && cpu_addr_i == rdb_pkg::SOFTWARE_RESET_CONTROL_OFS
       && cpu_wdata_i[rdb_pkg::RST_CORE_BIT])
      |=> core_regs_reset_o ##1 !core_regs_reset_o;
   endproperty
   a_core_rst_pulse: assert property (p_core_rst_pulse) // R1
      else $error("core reset pulse missing or too long");

   property p_core_rst_keeps;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (core_regs_reset_o && !all_regs_reset_o)
      |=> $stable(area_reg);
   endproperty
   a_core_rst_keeps: assert property (p_core_rst_keeps) // R1
      else $error("core reset disturbed bank registers");

   property p_all_rst;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      all_regs_reset_o |=> (dma_cfg_reg == rdb_pkg::DMA_CFG_RST
                            && area_reg == rdb_pkg::AREA_RST);
   endproperty
   a_all_rst: assert property (p_all_rst) // R2
      else $error("full reset left a register set");

   property p_reserved_zero;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      ##1 (dma_cfg_reg[rdb_pkg::COUNT_LO-1:rdb_pkg::BURST_HI+1] == 4'h0);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) // R3
      else $error("reserved dma bits stored");

   property p_area_write;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (wr_en && cpu_addr_i == rdb_pkg::AREA_FILLED_OFS && !all_rst_reg)
      |=> ##1 (iso_area_filled_o ==
               $past(cpu_wdata_i[rdb_pkg::ISO_BIT], 2)
               && intr_area_filled_o ==
               $past(cpu_wdata_i[rdb_pkg::INTR_BIT], 2)
               && async_area_filled_o ==
               $past(cpu_wdata_i[rdb_pkg::ASYNC_BIT], 2));
   endproperty
   a_area_write: assert property (p_area_write) // R12
      else $error("area flag not taken from write");

   property p_dir;
      @(posedge clk_sys_i) disable iff (!rst_n_i)
      (!dma_req_o && !all_rst_reg) |=> dma_to_ram_o ==
      !$past(dma_cfg_reg[rdb_pkg::DMA_DIR_BIT]);
   endproperty
   a_dir: assert property (p_dir) // R8
      else $error("direction not following select bit");

   c_core_rst: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      core_regs_reset_o);
   c_all_areas: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      area_reg == 3'h7);
   c_dma_run: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      dma_req_o ##[1:50] dma_done_o);
endmodule // rdb_regs

/* test/rdb_dma_partner.sv */
/*
 system dma controller model: answers dma_req_i with acknowledge pulses
 and counts them. assumes the request is active high on clk_sys_i.
*/
module rdb_dma_partner
(
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   // request side
   input wire logic dma_req_i,
   input wire logic slow_i,
   output logic dma_ack_o,
   output int beats_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int ph;
   int gap;
   // pin is filtered in the bank, so hold 3 high and at least 3 low
   assign gap = slow_i ? 9 : 3;
   always @(posedge clk_sys_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ph <= 0;
         dma_ack_o <= 1'b0;
         beats_o <= 0;
      end
      else if (ph == 0)
      begin
         // no new beat once the request is withdrawn
         if (dma_req_i === 1'b1)
         begin
            dma_ack_o <= 1'b1;
            beats_o <= beats_o + 1;
            ph <= gap + 2;
         end
      end
      else
      begin
         ph <= ph - 1;
         dma_ack_o <= (ph > gap);
      end
   end
endmodule // rdb_dma_partner

/* test/tb_rdb_regs.sv */
/*
 testbench for the reset, dma configuration and area-filled bank.
 assumes the dma partner model drives the acknowledge pin.
*/
module tb_rdb_regs;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] A_RST = rdb_pkg::SOFTWARE_RESET_CONTROL_OFS;
   localparam logic [11:0] A_CFG = rdb_pkg::DMA_CFG_OFS;
   localparam logic [11:0] A_AREA = rdb_pkg::AREA_FILLED_OFS;
   logic clk_sys_i = 1'b0;
   logic rst_n_i, cpu_cs_i, cpu_wr_i, cpu_rd_i, bus_wide_i, slow_i;
   logic [11:0] cpu_addr_i;
   logic [31:0] cpu_wdata_i, cpu_rdata_o, rd;
   logic cpu_rvalid_o, core_rst, all_rst, dma_ack_i, dma_req_o;
   logic dma_to_ram_o, dma_done_o, af_a, af_i, af_s;
   int beats;
   int errors = 0;
   int tests_run = 0;
   int core_n = 0;
   int all_n = 0;
   always #20 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i)
   begin
      core_n <= core_n + int'(core_rst === 1'b1);
      all_n <= all_n + int'(all_rst === 1'b1);
   end
   rdb_regs #(.COUNT_W(24)) dut_u (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cpu_cs_i(cpu_cs_i),
      .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i), .cpu_addr_i(cpu_addr_i),
      .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o),
      .cpu_rvalid_o(cpu_rvalid_o), .bus_wide_i(bus_wide_i),
      .core_regs_reset_o(core_rst), .all_regs_reset_o(all_rst),
      .dma_ack_i(dma_ack_i), .dma_req_o(dma_req_o),
      .dma_to_ram_o(dma_to_ram_o), .dma_done_o(dma_done_o),
      .async_area_filled_o(af_a), .intr_area_filled_o(af_i),
      .iso_area_filled_o(af_s));
   rdb_dma_partner far_u (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .dma_req_i(dma_req_o),
      .slow_i(slow_i), .dma_ack_o(dma_ack_i), .beats_o(beats));
   task automatic complete_run;
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // entered just after a rising edge, returns on one
   task automatic wr32(input logic [11:0] a, input logic [31:0] d);
      cpu_cs_i <= 1'b1;
      cpu_wr_i <= 1'b1;
      cpu_addr_i <= a;
      cpu_wdata_i <= d;
      @(posedge clk_sys_i);
      cpu_cs_i <= 1'b0;
      cpu_wr_i <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic rd32(input logic [11:0] a, output logic [31:0] d);
      bit got;
      got = 0;
      cpu_cs_i <= 1'b1;
      cpu_rd_i <= 1'b1;
      cpu_addr_i <= a;
      @(posedge clk_sys_i);
      cpu_cs_i <= 1'b0;
      cpu_rd_i <= 1'b0;
      for (int i = 0; i < 4 && !got; i++)
      begin
         #1;
         got = (cpu_rvalid_o === 1'b1);
         d = cpu_rdata_o;
         @(posedge clk_sys_i);
      end
      if (!got)
      begin
         errors++;
         complete_run();
      end
   endtask
   task automatic rchk(input string nm, input logic [11:0] a,
                       input logic [31:0] exp);
      rd32(a, rd);
      check(nm, rd, exp);
   endtask
   task automatic run_dma(input logic [1:0] sel, input logic w,
                          input logic sl, input logic dir);
      int b0;
      bit got;
      got = 0;
      bus_wide_i <= w;
      slow_i <= sl;
      b0 = beats;
      wr32(A_CFG, {24'h00_0010, 4'h0, sel, 1'b1, dir});
      for (int i = 0; i < 400 && !got; i++)
      begin
         @(posedge clk_sys_i);
         #1;
         got = (dma_done_o === 1'b1);
      end
      if (!got)
      begin
         errors++;
         complete_run();
      end
      check("to_ram", 32'(dma_to_ram_o), 32'(!dir));
      check("beats", 32'(beats - b0), w ? 32'h4 : 32'h8);
      @(posedge clk_sys_i);
      rchk("cfg_end", A_CFG, {24'h00_0010, 4'h0, sel, 1'b0, dir});
   endtask
   initial
   begin
      {cpu_cs_i, cpu_wr_i, cpu_rd_i, bus_wide_i, slow_i} = 5'h00;
      cpu_addr_i = 12'h000;
      cpu_wdata_i = 32'h0000_0000;
      rst_n_i = 1'b0;
      repeat (12) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      check("to_ram_rst", 32'(dma_to_ram_o), 32'h1);
      rchk("cfg_rst", A_CFG, 32'h0000_0000);
      rchk("area_rst", A_AREA, 32'h0000_0000);
      // flags written during initialisation, every combination
      for (int v = 7; v >= 0; v--)
      begin
         wr32(A_AREA, 32'(v));
         check("area_o", {29'h0, af_s, af_i, af_a}, 32'(v));
         rchk("area_rd", A_AREA, 32'(v));
      end
      // unmapped write is dropped and leaves neighbours alone
      wr32(12'h0338, 32'hFFFF_FFFF);
      rchk("unmapped", 12'h0338, 32'h0000_0000);
      rchk("area_keep", A_AREA, 32'h0000_0000);
      for (int k = 0; k < 8; k++)
         run_dma(2'(k), k[2], k[0], k[1]);
      // clearing run mid-transfer must stop the request
      wr32(A_CFG, 32'h0001_0002);
      repeat (20) @(posedge clk_sys_i);
      #1 check("req_on", 32'(dma_req_o), 32'h1);
      @(posedge clk_sys_i);
      wr32(A_CFG, 32'h0001_0000);
      @(posedge clk_sys_i);
      #1 check("req_stop", 32'(dma_req_o), 32'h0);
      @(posedge clk_sys_i);
      // core reset leaves this bank untouched
      wr32(A_AREA, 32'h0000_0005);
      wr32(A_CFG, 32'hABCD_EF0D);
      wr32(A_RST, 32'h0000_0002);
      @(posedge clk_sys_i);
      check("core_pulse", 32'(core_n), 32'h1);
      check("all_quiet", 32'(all_n), 32'h0);
      rchk("cfg_kept", A_CFG, 32'hABCD_EF0D);
      rchk("area_kept", A_AREA, 32'h0000_0005);
      rchk("rst_rd", A_RST, 32'h0000_0000);
      wr32(A_RST, 32'h0000_0001);
      repeat (2) @(posedge clk_sys_i);
      check("all_pulse", 32'(all_n), 32'h1);
      check("core_once", 32'(core_n), 32'h1);
      check("to_ram_all", 32'(dma_to_ram_o), 32'h1);
      check("area_all", {29'h0, af_s, af_i, af_a}, 32'h0);
      rchk("cfg_all", A_CFG, 32'h0000_0000);
      rchk("area_clr", A_AREA, 32'h0000_0000);
      complete_run();
   end
endmodule // tb_rdb_regs
